// ---- design/drive_sync_and_state_words.sv ----
// Drive object dictionary: input sync descriptor, error code, control and status words
//
// Overview of operation
// - Input sync type accepts 00h free run, 02h sync0, 22h sync manager event.
// - Cycle time field reports measured sync0 period in nanoseconds, read only.
// - Shift time is unsupported and always reads zero.
// - Supported types mask: bit0 free run, bit1 manager event, bit2 sync0.
// - Read-only field gives shortest supported cycle time in nanoseconds.
// - Read-only field gives minimum calc-and-copy time before sync0.
// - Delay time is unsupported and always reads zero.
// - Sync error flag goes to one when a synchronization error is seen.
// - Active alarm: error code low byte is alarm code, high byte FFh.
// - Without alarm the error code word reads zero.
// - Control bits 0 to 3 command the drive state transitions.
// - Alarm clears only on a rising edge of control bit 7.
// - Status bits 0 to 3, 5 and 6 reflect the drive state; bit 4 also needs main power.
// - Status bit 7 follows the information condition with no software action.
// - Status bit 9 is set once initialization completes.
// - Status bit 11 shows an internal limit restricting the drive.
// - Status bits 10, 12 and 13 come from the active operation mode.
// - Halt bit 8 stops per halt option, operation stays enabled.
`timescale 1ns/1ps
module drive_sync_and_state_words #(
  parameter logic [31:0] MIN_CYCLE_CYC =
    32'((drive_obj_pkg::MIN_CYCLE_NS + drive_obj_pkg::CLK_NS - 1) / drive_obj_pkg::CLK_NS)
) (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        obj_rd,
  input  wire logic        obj_wr,
  input  wire logic [15:0] obj_index,
  input  wire logic [7:0]  obj_sub,
  input  wire logic [31:0] obj_wdata,
  output logic      [31:0] obj_rdata,
  output logic             obj_ack,
  output logic             obj_abort,
  input  wire logic        sync0,
  input  wire logic        sm_event,
  input  wire logic        alarm_set,
  input  wire logic [7:0]  alarm_code_in,
  input  wire logic        init_done,
  input  wire logic        info_active,
  input  wire logic        internal_limit,
  input  wire logic        target_reached,
  input  wire logic [1:0]  mode_status,
  input  wire logic [2:0]  mfr_status,
  input  wire logic        main_power,
  input  wire logic        motion_stopped,
  output logic      [3:0]  mode_ctrl,
  output logic      [4:0]  mfr_ctrl,
  output logic             power_stage_on,
  output logic             operation_on,
  output logic      [1:0]  stop_mode,
  output logic             fault_active
);
  typedef struct packed {
    logic [15:0]                cw;
    logic                       fr_prev;
    logic [7:0]                 sync_type;
    logic [1:0]                 halt_opt;
    logic                       alarm;
    logic [7:0]                 alarm_code;
    drive_obj_pkg::drive_state_e st;
    logic [31:0]                rdata;
    logic                       ack;
    logic                       abort;
    logic                       err_clr;
  } regs_s;

  regs_s       q;
  regs_s       next_q;
  logic [31:0] cycle_ns;
  logic        sync_err;

  // Shutdown: voltage and quick stop set, switch on clear
  function automatic logic cmd_shutdown(input logic [15:0] cw);
    cmd_shutdown = cw[drive_obj_pkg::CW_EN_VOLT] && cw[drive_obj_pkg::CW_QSTOP] &&
                   !cw[drive_obj_pkg::CW_SWITCH_ON];
  endfunction

  function automatic logic cmd_switch_on(input logic [15:0] cw);
    cmd_switch_on = cw[drive_obj_pkg::CW_EN_VOLT] && cw[drive_obj_pkg::CW_QSTOP] &&
                    cw[drive_obj_pkg::CW_SWITCH_ON];
  endfunction

  function automatic logic cmd_enable_op(input logic [15:0] cw);
    cmd_enable_op = cmd_switch_on(cw) && cw[drive_obj_pkg::CW_EN_OP];
  endfunction

  function automatic logic cmd_disable_volt(input logic [15:0] cw);
    cmd_disable_volt = !cw[drive_obj_pkg::CW_EN_VOLT];
  endfunction

  function automatic logic cmd_quick_stop(input logic [15:0] cw);
    cmd_quick_stop = cw[drive_obj_pkg::CW_EN_VOLT] && !cw[drive_obj_pkg::CW_QSTOP];
  endfunction

  // State flags: bit0 ready, 1 switched on, 2 op enabled, 3 fault, 5 quick stop, 6 sod
  function automatic logic [6:0] state_bits(input drive_obj_pkg::drive_state_e s);
    unique case (s)
      drive_obj_pkg::ST_NOT_READY: state_bits = 7'b000_0000;
      drive_obj_pkg::ST_SW_ON_DIS: state_bits = 7'b100_0000;
      drive_obj_pkg::ST_READY:     state_bits = 7'b010_0001;
      drive_obj_pkg::ST_SWITCHED:  state_bits = 7'b010_0011;
      drive_obj_pkg::ST_OP_EN:     state_bits = 7'b010_0111;
      drive_obj_pkg::ST_QSTOP:     state_bits = 7'b000_0111;
      drive_obj_pkg::ST_FAULT_RCT: state_bits = 7'b000_1111;
      drive_obj_pkg::ST_FAULT:     state_bits = 7'b000_1000;
    endcase
  endfunction

  function automatic logic [15:0] status_word(
    input drive_obj_pkg::drive_state_e s,
    input logic                        volt,
    input logic                        info,
    input logic                        remote,
    input logic                        target,
    input logic                        limit,
    input logic [1:0]                  mode_st,
    input logic [2:0]                  mfr_st
  );
    logic [6:0] b;
    b = state_bits(s);
    status_word = {mfr_st[2:1], mode_st, limit, target, remote, mfr_st[0], info,
                   b[6:5], volt, b[3:0]};
  endfunction

  function automatic logic [15:0] error_word(input logic act, input logic [7:0] code);
    // alarm code with FFh on top
    error_word = act ? {drive_obj_pkg::ALARM_HIGH, code} : 16'h0000;
  endfunction

  always_comb begin
    logic        fr_edge;
    logic [15:0] sw;
    logic        hit;
    logic        ro;
    logic        bad;
    logic [31:0] rd;
    fr_edge        = 1'b0;
    next_q         = q;
    next_q.ack     = 1'b0;
    next_q.abort   = 1'b0;
    next_q.err_clr = 1'b0;
    hit            = 1'b1;
    ro             = 1'b1;
    bad            = 1'b0;
    rd             = 32'h0;
    sw = status_word(q.st, main_power && (q.st != drive_obj_pkg::ST_NOT_READY) &&
                     (q.st != drive_obj_pkg::ST_SW_ON_DIS),
                     info_active,
                     init_done,
                     target_reached,
                     internal_limit, mode_status, mfr_status);

    // Object read multiplexer
    if (obj_index == drive_obj_pkg::IDX_SYNC) begin
      unique case (obj_sub)
        drive_obj_pkg::SUB_ENTRIES:   rd = {24'h0, drive_obj_pkg::ENTRIES};
        drive_obj_pkg::SUB_TYPE: begin
          rd = {24'h0, q.sync_type};
          ro = 1'b0;
        end
        drive_obj_pkg::SUB_CYCLE:     rd = cycle_ns;
        drive_obj_pkg::SUB_SHIFT:     rd = drive_obj_pkg::SHIFT_NS;
        drive_obj_pkg::SUB_SUPPORTED: rd = {16'h0, drive_obj_pkg::SUPPORTED};
        drive_obj_pkg::SUB_MIN_CYCLE: rd = drive_obj_pkg::MIN_CYCLE_NS;
        drive_obj_pkg::SUB_CALC_COPY: rd = drive_obj_pkg::CALC_COPY_NS;
        drive_obj_pkg::SUB_DELAY:     rd = drive_obj_pkg::DELAY_NS;
        drive_obj_pkg::SUB_SYNC_ERR:  rd = {31'h0, sync_err};
        default:                      hit = 1'b0;
      endcase
    end else if (obj_index == drive_obj_pkg::IDX_ERR) begin
      rd = {16'h0, error_word(q.alarm, q.alarm_code)};
    end else if (obj_index == drive_obj_pkg::IDX_CW) begin
      rd = {16'h0, q.cw};
      ro = 1'b0;
    end else if (obj_index == drive_obj_pkg::IDX_SW) begin
      rd = {16'h0, sw};
    end else if (obj_index == drive_obj_pkg::IDX_HALT) begin
      rd = {30'h0, q.halt_opt};
      ro = 1'b0;
    end else begin
      hit = 1'b0;
    end
    if (obj_index != drive_obj_pkg::IDX_SYNC && obj_sub != drive_obj_pkg::SUB_ENTRIES) begin
      hit = 1'b0;
    end

    if (obj_rd || obj_wr) begin
      next_q.ack   = 1'b1;
      next_q.rdata = hit ? rd : 32'h0;
    end

    if (obj_wr && hit && !ro) begin
      if (obj_index == drive_obj_pkg::IDX_SYNC) begin
        if (obj_wdata[31:8] != 24'h0) begin
          bad = 1'b1;
        end else if (obj_wdata[7:0] == drive_obj_pkg::SYNC_FREE ||
                     obj_wdata[7:0] == drive_obj_pkg::SYNC_DC ||
                     obj_wdata[7:0] == drive_obj_pkg::SYNC_SM) begin
          next_q.sync_type = obj_wdata[7:0];
          // A new mode restarts error tracking
          next_q.err_clr   = 1'b1;
        end else begin
          bad = 1'b1;
        end
      end else if (obj_index == drive_obj_pkg::IDX_CW) begin
        next_q.cw = obj_wdata[15:0];
      end else begin
        if (obj_wdata[31:2] == 30'h0 && obj_wdata[1:0] != 2'h0) begin
          next_q.halt_opt = obj_wdata[1:0];
        end else begin
          bad = 1'b1;
        end
      end
    end
    if ((obj_rd || obj_wr) && (!hit || (obj_wr && ro) || bad)) next_q.abort = 1'b1;
    // Refused access returns zero data, never the old field value
    if (next_q.abort) next_q.rdata = 32'h0;

    fr_edge        = q.cw[drive_obj_pkg::CW_FAULT_RST] && !q.fr_prev;
    next_q.fr_prev = q.cw[drive_obj_pkg::CW_FAULT_RST];
    if (fr_edge) next_q.alarm = 1'b0;
    // A new alarm wins over a simultaneous reset
    if (alarm_set) begin
      next_q.alarm      = 1'b1;
      next_q.alarm_code = alarm_code_in;
    end

    unique case (q.st)
      drive_obj_pkg::ST_NOT_READY: begin
        if (init_done) next_q.st = drive_obj_pkg::ST_SW_ON_DIS;
      end
      drive_obj_pkg::ST_SW_ON_DIS: begin
        if (cmd_shutdown(q.cw)) next_q.st = drive_obj_pkg::ST_READY;
      end
      drive_obj_pkg::ST_READY: begin
        if (cmd_disable_volt(q.cw) || cmd_quick_stop(q.cw))
          next_q.st = drive_obj_pkg::ST_SW_ON_DIS;
        else if (cmd_enable_op(q.cw))
          next_q.st = drive_obj_pkg::ST_OP_EN;
        else if (cmd_switch_on(q.cw))
          next_q.st = drive_obj_pkg::ST_SWITCHED;
      end
      drive_obj_pkg::ST_SWITCHED: begin
        if (cmd_disable_volt(q.cw) || cmd_quick_stop(q.cw))
          next_q.st = drive_obj_pkg::ST_SW_ON_DIS;
        else if (cmd_shutdown(q.cw))
          next_q.st = drive_obj_pkg::ST_READY;
        else if (cmd_enable_op(q.cw))
          next_q.st = drive_obj_pkg::ST_OP_EN;
      end
      drive_obj_pkg::ST_OP_EN: begin
        if (cmd_disable_volt(q.cw))
          next_q.st = drive_obj_pkg::ST_SW_ON_DIS;
        else if (cmd_quick_stop(q.cw))
          next_q.st = drive_obj_pkg::ST_QSTOP;
        else if (cmd_shutdown(q.cw))
          next_q.st = drive_obj_pkg::ST_READY;
        else if (!cmd_enable_op(q.cw))
          next_q.st = drive_obj_pkg::ST_SWITCHED;
      end
      drive_obj_pkg::ST_QSTOP: begin
        // Power stays on until the motor is at rest or voltage is disabled
        if (cmd_disable_volt(q.cw) || motion_stopped)
          next_q.st = drive_obj_pkg::ST_SW_ON_DIS;
      end
      drive_obj_pkg::ST_FAULT_RCT: begin
        if (motion_stopped) next_q.st = drive_obj_pkg::ST_FAULT;
      end
      drive_obj_pkg::ST_FAULT: begin
        if (!next_q.alarm) next_q.st = drive_obj_pkg::ST_SW_ON_DIS;
      end
    endcase
    if (next_q.alarm && q.st != drive_obj_pkg::ST_FAULT &&
        q.st != drive_obj_pkg::ST_FAULT_RCT) begin
      next_q.st = drive_obj_pkg::ST_FAULT_RCT;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      q           <= '0;
      q.cw        <= drive_obj_pkg::CW_RST;
      q.sync_type <= drive_obj_pkg::SYNC_TYPE_RST;
      q.halt_opt  <= drive_obj_pkg::HALT_OPT_RST;
      q.st        <= drive_obj_pkg::ST_NOT_READY;
    end else begin
      q <= next_q;
    end
  end

  sync_monitor #(
    .MIN_CYCLE_CYC (MIN_CYCLE_CYC)
  ) u_sync_monitor (
    .clk       (clk),
    .rstn      (rstn),
    .sync_type (q.sync_type),
    .sync0     (sync0),
    .sm_event  (sm_event),
    .err_clear (q.err_clr),
    .cycle_ns  (cycle_ns),
    .sync_err  (sync_err)
  );

  stop_select u_stop_select (
    .clk       (clk),
    .rstn      (rstn),
    .state     (q.st),
    .halt      (q.cw[drive_obj_pkg::CW_HALT]),
    .halt_opt  (q.halt_opt),
    .stop_mode (stop_mode)
  );

  assign obj_rdata      = q.rdata;
  assign obj_ack        = q.ack;
  assign obj_abort      = q.abort;
  assign mode_ctrl      = {q.cw[9], q.cw[6:4]};
  assign mfr_ctrl       = q.cw[15:11];
  assign power_stage_on = (q.st == drive_obj_pkg::ST_SWITCHED) ||
                          (q.st == drive_obj_pkg::ST_OP_EN) ||
                          (q.st == drive_obj_pkg::ST_QSTOP) ||
                          (q.st == drive_obj_pkg::ST_FAULT_RCT);
  assign operation_on   = (q.st == drive_obj_pkg::ST_OP_EN);
  assign fault_active   = q.alarm;
endmodule // drive_sync_and_state_words

// ---- inc/drive_obj_pkg.sv ----
// Object indexes, field layouts, reset values and timing constants of the drive object block
package drive_obj_pkg;
  localparam int          CLK_NS        = 8;
  localparam logic [15:0] IDX_SYNC      = 16'h1c33;
  localparam logic [15:0] IDX_ERR       = 16'h603f;
  localparam logic [15:0] IDX_CW        = 16'h6040;
  localparam logic [15:0] IDX_SW        = 16'h6041;
  localparam logic [15:0] IDX_HALT      = 16'h605d;
  localparam logic [7:0]  SUB_ENTRIES   = 8'h00;
  localparam logic [7:0]  SUB_TYPE      = 8'h01;
  localparam logic [7:0]  SUB_CYCLE     = 8'h02;
  localparam logic [7:0]  SUB_SHIFT     = 8'h03;
  localparam logic [7:0]  SUB_SUPPORTED = 8'h04;
  localparam logic [7:0]  SUB_MIN_CYCLE = 8'h05;
  localparam logic [7:0]  SUB_CALC_COPY = 8'h06;
  localparam logic [7:0]  SUB_DELAY     = 8'h09;
  localparam logic [7:0]  SUB_SYNC_ERR  = 8'h20;
  localparam logic [7:0]  SYNC_FREE     = 8'h00;
  localparam logic [7:0]  SYNC_DC       = 8'h02;
  localparam logic [7:0]  SYNC_SM       = 8'h22;
  localparam logic [7:0]  SYNC_TYPE_RST = 8'h22;
  localparam logic [7:0]  ENTRIES       = 8'h20;
  localparam logic [15:0] SUPPORTED     = 16'h0007;
  localparam logic [31:0] MIN_CYCLE_NS  = 32'd500000;
  localparam logic [31:0] CALC_COPY_NS  = 32'd200000;
  localparam logic [31:0] SHIFT_NS      = 32'h0000_0000;
  localparam logic [31:0] DELAY_NS      = 32'h0000_0000;
  localparam logic [15:0] CW_RST        = 16'h0000;
  localparam logic [1:0]  HALT_OPT_RST  = 2'h1;
  localparam logic [7:0]  ALARM_HIGH    = 8'hff;
  localparam int          CW_SWITCH_ON  = 0;
  localparam int          CW_EN_VOLT    = 1;
  localparam int          CW_QSTOP      = 2;
  localparam int          CW_EN_OP      = 3;
  localparam int          CW_FAULT_RST  = 7;
  localparam int          CW_HALT       = 8;
  localparam int          SW_WARNING    = 7;
  localparam int          SW_REMOTE     = 9;
  localparam int          SW_TARGET     = 10;
  localparam int          SW_LIMIT      = 11;
  typedef enum logic [2:0] {
    ST_NOT_READY = 3'b000,
    ST_SW_ON_DIS = 3'b001,
    ST_READY     = 3'b010,
    ST_SWITCHED  = 3'b011,
    ST_OP_EN     = 3'b100,
    ST_QSTOP     = 3'b101,
    ST_FAULT_RCT = 3'b110,
    ST_FAULT     = 3'b111
  } drive_state_e;
  typedef enum logic [1:0] {
    STOP_NONE    = 2'b00,
    STOP_PROFILE = 2'b01,
    STOP_QUICK   = 2'b10,
    STOP_IMMED   = 2'b11
  } stop_e;
endpackage

// ---- design/sync_monitor.sv ----
// Sync0 period measurement and sync error detection
`timescale 1ns/1ps
module sync_monitor #(
  parameter logic [31:0] MIN_CYCLE_CYC = 32'd62500
) (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic [7:0]  sync_type,
  input  wire logic        sync0,
  input  wire logic        sm_event,
  input  wire logic        err_clear,
  output logic      [31:0] cycle_ns,
  output logic             sync_err
);
  typedef struct packed {
    logic [31:0] c0;
    logic        seen0;
    logic [31:0] ce;
    logic [31:0] last;
    logic        seen;
    logic        err;
    logic [31:0] cyc_ns;
  } mon_s;
  mon_s q;
  mon_s next_q;
  always_comb begin
    logic ev;
    logic det;
    ev     = 1'b0;
    det    = 1'b0;
    next_q = q;
    if (q.c0 != 32'hffff_ffff) next_q.c0 = q.c0 + 32'h1;
    if (q.ce != 32'hffff_ffff) next_q.ce = q.ce + 32'h1;
    if (sync0) begin
      if (q.seen0) next_q.cyc_ns = 32'((q.c0 + 32'h1) * drive_obj_pkg::CLK_NS);
      next_q.c0    = 32'h0;
      next_q.seen0 = 1'b1;
    end
    ev = (sync_type == drive_obj_pkg::SYNC_DC) ? sync0 : sm_event;
    if (sync_type != drive_obj_pkg::SYNC_FREE) begin
      if (ev && q.seen && (q.ce + 32'h1 < MIN_CYCLE_CYC)) det = 1'b1;
      if (q.seen && (q.ce > {q.last[30:0], 1'b0})) det = 1'b1;
    end
    if (ev) begin
      next_q.last = q.ce + 32'h1;
      next_q.ce   = 32'h0;
      next_q.seen = 1'b1;
    end
    // Detection wins over a clear in the same cycle
    if (err_clear) begin
      next_q.err  = 1'b0;
      next_q.seen = ev;
    end
    if (det) next_q.err = 1'b1;
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) q <= '0;
    else q <= next_q;
  end
  assign cycle_ns = q.cyc_ns;
  assign sync_err = q.err;
endmodule // sync_monitor

// ---- design/stop_select.sv ----
// Chooses how the motion stage brings the motor to rest
`timescale 1ns/1ps
module stop_select (
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic [2:0] state,
  input  wire logic       halt,
  input  wire logic [1:0] halt_opt,
  output logic      [1:0] stop_mode
);
  typedef struct packed {
    logic [1:0] mode;
  } sel_s;
  sel_s q;
  sel_s next_q;
  always_comb begin
    next_q = q;
    unique case (state)
      drive_obj_pkg::ST_QSTOP,
      drive_obj_pkg::ST_FAULT_RCT: next_q.mode = drive_obj_pkg::STOP_QUICK;
      drive_obj_pkg::ST_OP_EN: next_q.mode = halt ? halt_opt : drive_obj_pkg::STOP_NONE;
      default: next_q.mode = drive_obj_pkg::STOP_NONE;
    endcase
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) q <= '0;
    else q <= next_q;
  end
  assign stop_mode = q.mode;
endmodule // stop_select

// ---- tb/sync_source.sv ----
// Event source standing in for the master's sync0 and manager events
`timescale 1ns/1ps
module sync_source (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        run,
  input  wire logic [15:0] period,
  output logic             sync0,
  output logic             sm_event
);
  logic [15:0] cnt;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt <= 16'h0001;
      sync0 <= 1'b0;
    end else begin
      sync0 <= run && (cnt >= period);
      // Compare with >= so a shorter period takes effect at once
      cnt <= (!run || cnt >= period) ? 16'h0001 : cnt + 16'h0001;
    end
  end
  assign sm_event = sync0;
endmodule // sync_source

// ---- tb/drive_sync_and_state_words_assertions.sv ----
// Port-level checker for the drive object block
`timescale 1ns/1ps
module drive_obj_checker (
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic        obj_rd,
  input wire logic        obj_wr,
  input wire logic [15:0] obj_index,
  input wire logic [7:0]  obj_sub,
  input wire logic [31:0] obj_rdata,
  input wire logic        obj_ack,
  input wire logic        obj_abort,
  input wire logic        alarm_set,
  input wire logic        fault_active
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence rd_at(logic [15:0] i, logic [7:0] s);
    obj_rd && !obj_wr && obj_index == i && obj_sub == s;
  endsequence
  a_ack_follows_req: assert property ((obj_rd || obj_wr) |=> obj_ack)
    else $error("no ack one cycle after request");
  a_ack_has_cause: assert property (obj_ack |-> $past(obj_rd || obj_wr))
    else $error("ack without request");
  a_abort_zero_data: assert property (obj_abort |-> obj_ack && obj_rdata == 32'h0)
    else $error("abort without ack or with data");
  a_shift_reads_zero: assert property (rd_at(16'h1c33, 8'h03) |=> obj_rdata == 32'h0)
    else $error("shift time not zero");
  a_delay_reads_zero: assert property (rd_at(16'h1c33, 8'h09) |=> obj_rdata == 32'h0)
    else $error("delay time not zero");
  a_types_mask: assert property (rd_at(16'h1c33, 8'h04) |=> obj_rdata == 32'h7)
    else $error("supported mask wrong");
  a_err_code_form: assert property (rd_at(16'h603f, 8'h00) |=> $past(fault_active) ?
    obj_rdata[31:8] == 24'h0000ff : obj_rdata == 32'h0)
    else $error("error code form wrong");
  a_fault_set_cause: assert property ($rose(fault_active) |-> $past(alarm_set))
    else $error("fault without alarm");
  a_fault_clear_cause: assert property ($fell(fault_active) |->
    $past(obj_wr && obj_index == 16'h6040, 2))
    else $error("fault cleared without control write");
  c_abort: cover property (obj_abort);
  c_fault: cover property ($fell(fault_active));
  c_err_read: cover property (rd_at(16'h603f, 8'h00) ##1 fault_active);
endmodule // drive_obj_checker
bind drive_sync_and_state_words drive_obj_checker i_chk (.clk(clk), .rstn(rstn),
  .obj_rd(obj_rd), .obj_wr(obj_wr), .obj_index(obj_index), .obj_sub(obj_sub),
  .obj_rdata(obj_rdata), .obj_ack(obj_ack), .obj_abort(obj_abort),
  .alarm_set(alarm_set), .fault_active(fault_active));

// ---- tb/drive_sync_and_state_words_bench.sv ----
// Bench for the drive object block: object access, sync, state and alarm tests
`timescale 1ns/1ps
module drive_sync_and_state_words_bench;
  logic        clk, rstn, obj_rd, obj_wr, sync0, sm_event, alarm_set, init_done, run;
  logic        info_active, internal_limit, target_reached, main_power, motion_stopped;
  logic        obj_ack, obj_abort, power_stage_on, operation_on, fault_active, ab;
  logic [15:0] obj_index, period;
  logic [7:0]  obj_sub, alarm_code_in;
  logic [31:0] obj_wdata, obj_rdata, rd;
  logic [1:0]  mode_status, stop_mode;
  logic [2:0]  mfr_status;
  logic [3:0]  mode_ctrl;
  logic [4:0]  mfr_ctrl;
  int          errors, n_tests, cyc;
  logic [7:0]  subs[8] = '{8'h00, 8'h01, 8'h03, 8'h04, 8'h05, 8'h06, 8'h09, 8'h20};
  logic [31:0] exps[8] = '{32'h20, 32'h22, 32'h0, 32'h7, 32'h0007a120, 32'h00030d40,
                           32'h0, 32'h0};
  logic [7:0]  types[3] = '{8'h00, 8'h02, 8'h22};
  drive_sync_and_state_words #(.MIN_CYCLE_CYC(32'd16)) i_dut (.clk(clk), .rstn(rstn),
    .obj_rd(obj_rd), .obj_wr(obj_wr), .obj_index(obj_index), .obj_sub(obj_sub),
    .obj_wdata(obj_wdata), .obj_rdata(obj_rdata), .obj_ack(obj_ack),
    .obj_abort(obj_abort), .sync0(sync0), .sm_event(sm_event), .alarm_set(alarm_set),
    .alarm_code_in(alarm_code_in), .init_done(init_done), .info_active(info_active),
    .internal_limit(internal_limit), .target_reached(target_reached),
    .mode_status(mode_status), .mfr_status(mfr_status), .main_power(main_power),
    .motion_stopped(motion_stopped), .mode_ctrl(mode_ctrl), .mfr_ctrl(mfr_ctrl),
    .power_stage_on(power_stage_on), .operation_on(operation_on),
    .stop_mode(stop_mode), .fault_active(fault_active));
  sync_source i_src (.clk(clk), .rstn(rstn), .run(run), .period(period),
    .sync0(sync0), .sm_event(sm_event));
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One object access; the strobe is a single-cycle pulse and ack comes one edge later
  task automatic access(input logic w, input logic [15:0] idx, input logic [7:0] sub,
                        input logic [31:0] wd);
    @(posedge clk) #1;
    obj_wr = w;
    obj_rd = !w;
    obj_index = idx;
    obj_sub = sub;
    obj_wdata = wd;
    @(posedge clk) #1;
    obj_wr = 1'b0;
    obj_rd = 1'b0;
    rd = obj_rdata;
    ab = obj_abort;
    check("ack", {31'h0, obj_ack}, 32'h1);
  endtask
  task automatic wr(input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] wd,
                    input logic exp_ab);
    access(1'b1, idx, sub, wd);
    check("abort", {31'h0, ab}, {31'h0, exp_ab});
  endtask
  task automatic state_is(input logic [31:0] exp);
    access(1'b0, 16'h6041, 8'h00, 32'h0);
    check("state bits", rd & 32'h4f, exp);
  endtask
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      errors++;
      conclude();
    end
  end
  initial begin
    {rstn, obj_rd, obj_wr, alarm_set, info_active, internal_limit, target_reached} = '0;
    {obj_index, obj_sub, obj_wdata, alarm_code_in, mode_status, mfr_status, run} = '0;
    {init_done, main_power, motion_stopped} = 3'b111;
    period = 16'd20;
    repeat (5) @(posedge clk);
    #1 rstn = 1'b1;
    for (int i = 0; i < 8; i++) begin
      access(1'b0, 16'h1c33, subs[i], 32'h0);
      check("sync field", rd, exps[i]);
    end
    $display("test sync fields done");
    foreach (types[i]) begin
      wr(16'h1c33, 8'h01, {24'h0, types[i]}, 1'b0);
      access(1'b0, 16'h1c33, 8'h01, 32'h0);
      check("sync type", rd, {24'h0, types[i]});
    end
    wr(16'h1c33, 8'h01, 32'h01, 1'b1);
    wr(16'h1c33, 8'h01, 32'h122, 1'b1);
    wr(16'h603f, 8'h00, 32'h0, 1'b1);
    wr(16'h6040, 8'h01, 32'h0, 1'b1);
    access(1'b0, 16'h1234, 8'h00, 32'h0);
    check("unmapped data", rd, 32'h0);
    $display("test sync types and refusals done");
    run = 1'b1;
    repeat (80) @(posedge clk);
    access(1'b0, 16'h1c33, 8'h02, 32'h0);
    check("cycle time", rd, 32'd160);
    access(1'b0, 16'h1c33, 8'h20, 32'h0);
    check("no sync error", rd, 32'h0);
    period = 16'd5;
    repeat (30) @(posedge clk);
    access(1'b0, 16'h1c33, 8'h20, 32'h0);
    check("sync error", rd, 32'h1);
    run = 1'b0;
    $display("test sync timing done");
    state_is(32'h40);
    check("power off", {31'h0, power_stage_on}, 32'h0);
    wr(16'h6040, 8'h00, 32'h0006, 1'b0);
    state_is(32'h01);
    wr(16'h6040, 8'h00, 32'h0007, 1'b0);
    state_is(32'h03);
    wr(16'h6040, 8'h00, 32'h000f, 1'b0);
    state_is(32'h07);
    check("power on", {31'h0, power_stage_on}, 32'h1);
    wr(16'h6040, 8'h00, 32'hfe7f, 1'b0);
    check("mode ctrl", {28'h0, mode_ctrl}, 32'hf);
    check("mfr ctrl", {27'h0, mfr_ctrl}, 32'h1f);
    state_is(32'h07);
    wr(16'h605d, 8'h00, 32'h0, 1'b1);
    for (int o = 1; o <= 3; o++) begin
      wr(16'h605d, 8'h00, o, 1'b0);
      wr(16'h6040, 8'h00, 32'h010f, 1'b0);
      repeat (3) @(posedge clk);
      check("stop mode", {30'h0, stop_mode}, o);
      check("op kept", {31'h0, operation_on}, 32'h1);
      wr(16'h6040, 8'h00, 32'h000f, 1'b0);
    end
    $display("test states and halt done");
    wr(16'h6040, 8'h00, 32'h0080, 1'b0);
    @(posedge clk) #1;
    alarm_code_in = 8'h3c;
    alarm_set = 1'b1;
    @(posedge clk) #1;
    alarm_set = 1'b0;
    access(1'b0, 16'h603f, 8'h00, 32'h0);
    check("error code", rd, 32'hff3c);
    state_is(32'h08);
    wr(16'h6040, 8'h00, 32'h0080, 1'b0);
    access(1'b0, 16'h603f, 8'h00, 32'h0);
    check("no edge keeps alarm", rd, 32'hff3c);
    wr(16'h6040, 8'h00, 32'h0000, 1'b0);
    wr(16'h6040, 8'h00, 32'h0080, 1'b0);
    access(1'b0, 16'h603f, 8'h00, 32'h0);
    check("error code clear", rd, 32'h0);
    check("fault latch", {31'h0, fault_active}, 32'h0);
    $display("test alarm done");
    {info_active, internal_limit, target_reached} = 3'b111;
    mode_status = 2'h2;
    mfr_status = 3'h7;
    access(1'b0, 16'h6041, 8'h00, 32'h0);
    check("status flags", rd & 32'hff80, 32'hef80);
    info_active = 1'b0;
    access(1'b0, 16'h6041, 8'h00, 32'h0);
    check("warning clear", rd & 32'h0080, 32'h0);
    $display("test status flags done");
    conclude();
  end
endmodule // drive_sync_and_state_words_bench
